// [include/slnp_defs.svh]
`ifndef SLNP_DEFS_SVH
`define SLNP_DEFS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define SLNP_CTRL_OFS 32'h0000_0000
`define SLNP_STAT_OFS 32'h0000_0004
`define SLNP_ADDR_LSB 2
`define SLNP_ADDR_MSB 3

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define SLNP_CTRL_EN_BIT 0
`define SLNP_CTRL_HOLD_BIT 1
`define SLNP_CTRL_RST 2'h1

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define SLNP_STAT_BYTE_LSB 0
`define SLNP_STAT_LVL_LSB 8
`define SLNP_STAT_OVF_BIT 16
`define SLNP_STAT_SEL_BIT 17
`define SLNP_STAT_PEND_BIT 18
`define SLNP_STAT_OVF_LANE 2

// ----------------------------------------------------------------------------
// byte fields
// ----------------------------------------------------------------------------
`define SLNP_NIB_LSB 0
`define SLNP_NIB_MSB 3
`define SLNP_SPA_BIT 4
`define SLNP_SPB_BIT 5
`define SLNP_RSEL_BIT 6
`define SLNP_STB_BIT 7
`define SLNP_BYTE_RST 8'h00

// ----------------------------------------------------------------------------
// sizes and answers
// ----------------------------------------------------------------------------
`define SLNP_FIFO_WIDTH 8
`define SLNP_FIFO_DEPTH 16
`define SLNP_BITS_PER_BYTE 3'h7
`define SLNP_RESP_OKAY 2'h0
`define SLNP_RESP_SLVERR 2'h2

`endif

// [include/slnp_pkg.sv]
package slnp_pkg;
    typedef logic [7:0] slnp_byte_t;
    typedef logic [1:0] slnp_resp_t;
    typedef logic [4:0] slnp_level_t;
    // rx framing: gray along idle -> shifting
    typedef enum logic [0:0] {
        SLNP_RX_IDLE = 1'b0,
        SLNP_RX_SHIFT = 1'b1
    } slnp_rx_state_t;
endpackage : slnp_pkg

// [include/slnp_stream_if.sv]
`timescale 1ns/1ns
interface slnp_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : slnp_stream_if

// [verilog/slnp_fifo.sv]
`timescale 1ns/1ns
module slnp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    slnp_stream_if.snk push,
    slnp_stream_if.src pop,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic [WIDTH-1:0] out_q;
    logic out_vld_q;

    wire do_push = push.valid && push.ready;
    // output stage refills whenever the fifo holds a byte and the stage is empty or being drained
    wire do_load = (cnt_q != '0) && (!out_vld_q || pop.ready);
    wire do_pop = out_vld_q && pop.ready;

    assign push.ready = (cnt_q != FULL_CNT);
    assign pop.data = out_q;
    assign pop.valid = out_vld_q;
    assign level = cnt_q + {{AW{1'b0}}, out_vld_q};

    always_ff @(posedge clk_sys) begin
        if (ce && do_push) begin
            mem_q[wr_ptr_q] <= push.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            out_vld_q <= 1'b0;
        end else if (ce) begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_load) begin
                out_q <= mem_q[rd_ptr_q];
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_load);
            out_vld_q <= do_load || (out_vld_q && !do_pop);
        end
    end
endmodule : slnp_fifo

// [verilog/slnp_top.sv]
`timescale 1ns/1ns
`include "slnp_defs.svh"
// Overview of operation
// R01: the low nibble of each byte drives the four upper lcd data lines.
// R02: byte bits four and five go to two spare outputs unconnected to the lcd.
// R03: byte bit six drives register select, zero for command and one for data.
// R04: byte bit seven drives the lcd strobe, one asserted and zero released.
// R05: the host builds each lcd write from three transfers, strobe clear, set, clear.
// R06: the four lower lcd data lines are never driven by the port.
// R07: the lcd read/write line is held at write and nothing is read back.
// R08: the host runs the lcd in four-bit mode with at most eighty characters.
// R09: serial bytes are taken only while the host holds the select active.
// R10: the host waits out the lcd worst-case execution time between writes.
// R11: the parallel outputs hold the last complete byte until a new one arrives; while the hold bit is set, up to 17 bytes wait in the fifo, the rest drop.
module slnp_top
    import slnp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_ss_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] lcd_upper_data_lines,
    output logic spare_output_a,
    output logic spare_output_b,
    output logic register_select_bit,
    output logic lcd_strobe,
    output logic lcd_read_not_write,
    output logic [3:0] lcd_lower_data_lines,
    output logic [3:0] lcd_lower_data_lines_oe
);

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] sclk_q;
    logic [1:0] mosi_q;
    logic [1:0] ssn_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 3'h0;
            mosi_q <= 2'h0;
            ssn_q <= 2'h3;
        end else if (ce) begin
            sclk_q <= {sclk_q[1:0], spi_sclk};
            mosi_q <= {mosi_q[0], spi_mosi};
            ssn_q <= {ssn_q[0], spi_ss_n};
        end
    end

    // edge found from stages two and three only; stage one feeds stage two alone
    wire sclk_rise = sclk_q[1] && !sclk_q[2];
    wire mosi_s = mosi_q[1];
    wire ss_active = !ssn_q[1];

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    logic [1:0] ctrl_q;
    logic ovf_q;
    wire port_en = ctrl_q[`SLNP_CTRL_EN_BIT];
    wire drain_hold = ctrl_q[`SLNP_CTRL_HOLD_BIT];

    // ------------------------------------------------------------------------
    // serial receiver
    // ------------------------------------------------------------------------
    slnp_rx_state_t rx_state_q;
    slnp_rx_state_t rx_state_d;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;

    slnp_stream_if #(.WIDTH(`SLNP_FIFO_WIDTH)) rx_if ();
    slnp_stream_if #(.WIDTH(`SLNP_FIFO_WIDTH)) tx_if ();
    logic [4:0] fifo_level;

    // a byte only counts while selected and the port is enabled
    wire rx_go = ss_active && port_en; // see R09
    wire rx_bit = rx_go && sclk_rise; // see R09
    wire rx_done = rx_bit && (bit_cnt_q == `SLNP_BITS_PER_BYTE);
    wire [7:0] rx_byte = {shift_q, mosi_s};
    // the host clock cannot be stalled, so a full fifo drops the byte
    wire rx_drop = rx_done && !rx_if.ready;

    assign rx_if.valid = rx_done;
    assign rx_if.data = rx_byte;

    always_comb begin
        rx_state_d = rx_state_q;
        unique case (rx_state_q)
            SLNP_RX_IDLE: begin
                if (rx_go) begin
                    rx_state_d = SLNP_RX_SHIFT;
                end
            end
            SLNP_RX_SHIFT: begin
                if (!rx_go) begin
                    rx_state_d = SLNP_RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= SLNP_RX_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
        end else if (ce) begin
            rx_state_q <= rx_state_d;
            // a partial byte is thrown away when select drops
            if (rx_state_q == SLNP_RX_IDLE || !rx_go) begin
                bit_cnt_q <= 3'h0; // see R09
            end else if (rx_bit) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                shift_q <= rx_byte[6:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // byte buffer
    // ------------------------------------------------------------------------
    slnp_fifo #(
        .WIDTH(`SLNP_FIFO_WIDTH),
        .DEPTH(`SLNP_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .push(rx_if),
        .pop(tx_if),
        .level(fifo_level)
    );

    // ------------------------------------------------------------------------
    // parallel output latch
    // ------------------------------------------------------------------------
    slnp_byte_t out_q;
    wire out_load = tx_if.valid && !drain_hold;
    assign tx_if.ready = !drain_hold;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= `SLNP_BYTE_RST;
        end else if (ce && out_load) begin
            out_q <= tx_if.data; // see R11
        end
    end

    assign lcd_upper_data_lines = out_q[`SLNP_NIB_MSB:`SLNP_NIB_LSB]; // see R01
    assign spare_output_a = out_q[`SLNP_SPA_BIT]; // see R02
    assign spare_output_b = out_q[`SLNP_SPB_BIT]; // see R02
    assign register_select_bit = out_q[`SLNP_RSEL_BIT]; // see R03
    assign lcd_strobe = out_q[`SLNP_STB_BIT]; // see R04

    // lower lines and read/write are fixed flops so every output is registered
    logic [3:0] lower_q;
    logic [3:0] lower_oe_q;
    logic rnw_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lower_q <= 4'h0;
            lower_oe_q <= 4'h0;
            rnw_q <= 1'b0;
        end else if (ce) begin
            lower_q <= 4'h0; // see R06
            lower_oe_q <= 4'h0; // see R06
            rnw_q <= 1'b0; // see R07
        end
    end

    assign lcd_lower_data_lines = lower_q;
    assign lcd_lower_data_lines_oe = lower_oe_q;
    assign lcd_read_not_write = rnw_q;

    // ------------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------------
    logic aw_hold_q;
    logic w_hold_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    slnp_resp_t bresp_q;

    wire aw_take = s_axi_awvalid && awready_q;
    wire w_take = s_axi_wvalid && wready_q;
    wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
    wire wr_ctrl = do_write && (awaddr_q == `SLNP_CTRL_OFS);
    wire wr_stat = do_write && (awaddr_q == `SLNP_STAT_OFS);
    wire wr_bad = do_write && !wr_ctrl && !wr_stat;
    wire aw_hold_d = (aw_hold_q || aw_take) && !do_write;
    wire w_hold_d = (w_hold_q || w_take) && !do_write;
    wire bvalid_d = do_write || (bvalid_q && !s_axi_bready);
    // overflow clears by writing one; a drop in the same cycle wins
    wire ovf_clr = wr_stat && wstrb_q[`SLNP_STAT_OVF_LANE] && wdata_q[`SLNP_STAT_OVF_BIT];
    wire ovf_d = rx_drop || (ovf_q && !ovf_clr);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `SLNP_RESP_OKAY;
        end else if (ce) begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            if (aw_take) begin
                awaddr_q <= {s_axi_awaddr[31:2], 2'h0};
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            awready_q <= !aw_hold_d && !bvalid_d;
            wready_q <= !w_hold_d && !bvalid_d;
            bvalid_q <= bvalid_d;
            if (do_write) begin
                bresp_q <= wr_bad ? `SLNP_RESP_SLVERR : `SLNP_RESP_OKAY;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SLNP_CTRL_RST;
            ovf_q <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl && wstrb_q[0]) begin
                ctrl_q <= wdata_q[1:0];
            end
            ovf_q <= ovf_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------------
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    slnp_resp_t rresp_q;

    wire ar_take = s_axi_arvalid && arready_q;
    wire [31:0] ar_word = {s_axi_araddr[31:2], 2'h0};
    wire rd_ctrl = (ar_word == `SLNP_CTRL_OFS);
    wire rd_stat = (ar_word == `SLNP_STAT_OFS);
    wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
    wire [31:0] ctrl_word = {30'h0000_0000, ctrl_q};
    wire [31:0] stat_word = {13'h0000, tx_if.valid, ss_active, ovf_q,
                             3'h0, fifo_level, out_q};
    wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0000_0000);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `SLNP_RESP_OKAY;
        end else if (ce) begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= rd_word;
                rresp_q <= (rd_ctrl || rd_stat) ? `SLNP_RESP_OKAY : `SLNP_RESP_SLVERR;
            end
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : slnp_top

// [tb/slnp_spi_host.sv]
`timescale 1ns/1ns
// ----------------------------------------
// host end of the serial link, mode 0
// ----------------------------------------
module slnp_spi_host (
    output logic spi_sclk,
    output logic spi_mosi,
    output logic spi_ss_n
);
    initial begin
        spi_sclk = 1'b0;
        spi_mosi = 1'b1;
        spi_ss_n = 1'b1;
    end

    // n below 8 leaves a partial byte; 1 ns skew keeps sclk off clk_sys edges when xfer starts on a clk_sys edge
    task automatic xfer(input logic [7:0] b, input int n);
        #1 spi_ss_n = 1'b0;
        #24;
        for (int i = 0; i < n; i++) begin
            spi_mosi = b[7 - i];
            #24 spi_sclk = 1'b1;
            #24 spi_sclk = 1'b0;
        end
        #24 spi_ss_n = 1'b1;
        spi_mosi = ~spi_mosi; // released line must not show a stale bit
    endtask : xfer
endmodule : slnp_spi_host

// [tb/slnp_props.sv]
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module slnp_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lcd_read_not_write,
    input wire logic [3:0] lcd_lower_data_lines,
    input wire logic [3:0] lcd_lower_data_lines_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    a_rw_write: assert property (lcd_read_not_write == 1'b0)
        else $error("read/write line left write");
    a_lower_low: assert property (lcd_lower_data_lines == 4'h0)
        else $error("lower data lines not low");
    a_lower_float: assert property (lcd_lower_data_lines_oe == 4'h0)
        else $error("lower data lines driven");
    a_write_answer: assert property (s_wtake |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_write_busy: assert property (s_wtake |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while busy");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer wrong");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
endmodule : slnp_props

bind slnp_top slnp_props u_props (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .lcd_read_not_write,
    .lcd_lower_data_lines, .lcd_lower_data_lines_oe);

// [tb/tb_top.sv]
`timescale 1ns/1ns
// ----------------------------------------
// bench
// ----------------------------------------
module tb_top;
    logic clk_sys, rst_n, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, spare_output_a, spare_output_b;
    logic register_select_bit, lcd_strobe, lcd_read_not_write;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, lcd_upper_data_lines, lcd_lower_data_lines;
    logic [3:0] lcd_lower_data_lines_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    wire logic spi_sclk, spi_mosi, spi_ss_n;
    int failures = 0;
    int compares = 0;
    logic [7:0] seq [6] = '{8'h45, 8'hC5, 8'h45, 8'h3A, 8'hBA, 8'h3A};

    slnp_spi_host host (.spi_sclk, .spi_mosi, .spi_ss_n);
    slnp_top DUT (.*);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, v, input logic [3:0] s, output logic [1:0] q);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                q = s_axi_bresp;
                done = 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] q);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                v = s_axi_rdata;
                q = s_axi_rresp;
                done = 1'b1;
            end
        end
        s_axi_rready <= 1'b0;
    endtask : rd

    // give the sync and fifo path time to land, then look at the pins and the status byte
    task automatic pins(input logic [7:0] b);
        repeat (20) @(posedge clk_sys);
        chk("upper", lcd_upper_data_lines, b[3:0]);
        chk("spare_a", spare_output_a, b[4]);
        chk("spare_b", spare_output_b, b[5]);
        chk("rsel", register_select_bit, b[6]);
        chk("strobe", lcd_strobe, b[7]);
        chk("lower", {lcd_lower_data_lines_oe, lcd_lower_data_lines}, 8'h00);
        chk("rw", lcd_read_not_write, 1'b0);
        rd(32'h4, d, r);
        chk("stat_byte", d[7:0], b);
    endtask : pins

    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        #60000;
        failures++;
        results();
    end

    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        ce = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        pins(8'h00);
        rd(32'h0, d, r);
        chk("ctrl_rst", d, 32'h1);
        chk("ctrl_rresp", r, 2'h0);
        // lcd writes with nibble, select and spare bits, strobe clear/set/clear
        for (int i = 0; i < 6; i++) begin
            host.xfer(seq[i], 8);
            pins(seq[i]);
            repeat (10) @(posedge clk_sys);
        end
        host.xfer(8'hFF, 4);
        pins(8'h3A);
        host.xfer(8'h81, 8);
        pins(8'h81);
        wr(32'h0, 32'h0, 4'hF, r);
        host.xfer(8'h42, 8);
        pins(8'h81);
        wr(32'h0, 32'h1, 4'hE, r);
        rd(32'h0, d, r);
        chk("ctrl_lane", d, 32'h0);
        wr(32'h0, 32'h3, 4'hF, r);
        for (int i = 0; i < 18; i++) host.xfer(8'h10 + 8'(i), 8);
        pins(8'h81);
        rd(32'h4, d, r);
        chk("stat_full", d, 32'h0005_1181);
        wr(32'h0, 32'h1, 4'hF, r);
        repeat (200) @(posedge clk_sys);
        pins(8'h20);
        wr(32'h4, 32'h0001_0000, 4'h4, r);
        chk("clr_resp", r, 2'h0);
        rd(32'h4, d, r);
        chk("stat_clr", d, 32'h0000_0020);
        rd(32'h8, d, r);
        chk("unmapped_rd", d, 32'h0);
        chk("unmapped_rresp", r, 2'h2);
        wr(32'hC, 32'h1, 4'hF, r);
        chk("unmapped_wr", r, 2'h2);
        // clock enable low: a whole byte on the link must leave no trace
        @(posedge clk_sys);
        ce <= 1'b0;
        host.xfer(8'h99, 8);
        @(posedge clk_sys);
        ce <= 1'b1;
        pins(8'h20);
        results();
    end
endmodule : tb_top
